//--- include/irq_flag_pkg.sv
// Purpose: constants and carrier types for the peripheral request flag bank
// Assumes: 32-bit APB, one aligned word per register
// Notes: offsets of both request registers and the interrupt group are local choices
package irq_flag_pkg;

  localparam logic [11:0] OFS_FLAGS1 = 12'h000;
  localparam logic [11:0] OFS_FLAGS2 = 12'h004;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h008;
  localparam logic [11:0] OFS_IRQ_CLEAR = 12'h00c;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h010;

  // first request register bit positions
  localparam int F1_TIMER_A_OVF = 0;
  localparam int F1_TIMER_B_MATCH = 1;
  localparam int F1_BUS_COLLISION = 2;
  localparam int F1_SYNC_SERIAL = 3;
  localparam int F1_UART_TX_EMPTY = 4;
  localparam int F1_UART_RX_PEND = 5;

  // second request register bit positions
  localparam int F2_OSC_ROLLOVER = 0;
  localparam int F2_TIMER_D_MATCH = 1;
  localparam int F2_MEMORY_DONE = 4;
  localparam int F2_COMPARATOR_ONE = 5;
  localparam int F2_COMPARATOR_TWO = 6;
  localparam int F2_TIMER_F_MATCH = 7;

  // writable (software clearable) flags of each register
  localparam logic [7:0] F1_RW_MASK = 8'h0f;
  localparam logic [7:0] F2_RW_MASK = 8'hf3;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] IRQ_RESET = 16'h0000;

  // one-cycle peripheral event pulses
  typedef struct packed {
    logic syncSerialDone;
    logic busCollision;
    logic timerBMatch;
    logic timerAOverflow;
    logic timerFMatch;
    logic comparatorTwo;
    logic comparatorOne;
    logic memoryDone;
    logic timerDMatch;
    logic oscRollover;
  } periph_events_t;

  // levels from the asynchronous serial port
  typedef struct packed {
    logic rxNotEmpty;
    logic txEmpty;
  } uart_levels_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

endpackage

//--- verilog/peripheral_irq_flag_bank.sv
// Purpose: sticky peripheral interrupt request flags, read and cleared over APB
// Assumes: event inputs are one-cycle pulses from logic on the same clock
// Notes: a set in the same cycle as a software clear wins
//
// Functional notes
// RULE_01 - the serial port flag is set when a transfer or bus condition completes, not before.
// RULE_02 - a serial bus collision sets bit 2 of the first request register.
// RULE_03 - a set flag stays set until software writes it to zero; hardware never clears it.
// RULE_04 - an overflow of the first timer sets bit 0 of the first request register.
// RULE_05 - every flag is set whenever its triggering event occurs.
// RULE_06 - setting a flag does not depend on any enable bit.
// RULE_07 - software should clear a pending flag before enabling its interrupt.
// RULE_08 - bits 3 and 2 of the second request register read zero and ignore writes.
// RULE_09 - every implemented flag of the second register resets to zero on any reset.
// RULE_10 - the uart receive and transmit flags are read-only mirrors of buffer state.
// RULE_11 - a sixth timer match sets bit 7 of the second request register.
// RULE_12 - a memory programming completion sets bit 4 of the second request register.
// RULE_13 - an oscillator rollover sets bit 0 of the second request register.
// RULE_14 - a second timer match sets bit 1 of the first request register and stays set.
// RULE_15 - second register layout: 7 timer f, 6 comp two, 5 comp one, 4 memory, 1 timer d, 0 osc.
`timescale 1ns/1ps

module peripheral_irq_flag_bank
  import irq_flag_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input irq_flag_pkg::apb_req_t apbReq,
  output irq_flag_pkg::apb_rsp_t apbRsp,
  input irq_flag_pkg::periph_events_t events,
  input irq_flag_pkg::uart_levels_t uartLevels,
  output logic irqOut
);
  import irq_flag_pkg::*;

  // ==========================================================
  // bus decode
  // ==========================================================
  // single address compare, used by the write strobes only; the read mux decodes with its own case
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
    hit = (addr == ofs);
  endfunction

  // true for every offset with a register behind it
  function automatic logic mapped(input logic [11:0] addr);
    mapped = 1'b0;
    case (addr)
      OFS_FLAGS1: begin
        mapped = 1'b1;
      end
      OFS_FLAGS2: begin
        mapped = 1'b1;
      end
      OFS_IRQ_STATUS: begin
        mapped = 1'b1;
      end
      OFS_IRQ_CLEAR: begin
        mapped = 1'b1;
      end
      OFS_IRQ_ENABLE: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  endfunction

  // zero written clears a writable bit, one leaves it, read-only bits hold
  function automatic logic [7:0] clearByZero(
    input logic [7:0] cur,
    input logic [7:0] wdata,
    input logic [7:0] mask
  );
    clearByZero = (cur & ~mask) | (cur & wdata & mask);
  endfunction

  // one register word for a read, zero in every bit the register lacks
  function automatic logic [31:0] readWord(
    input logic [11:0] addr,
    input logic [7:0] view1,
    input logic [7:0] view2,
    input logic [15:0] status,
    input logic [15:0] enable
  );
    readWord = 32'h0000_0000;
    case (addr)
      OFS_FLAGS1: begin
        readWord[7:0] = view1;
      end
      OFS_FLAGS2: begin
        readWord[7:0] = view2;
      end
      OFS_IRQ_STATUS: begin
        readWord[15:0] = status;
      end
      OFS_IRQ_CLEAR: begin
        readWord = 32'h0000_0000;
      end
      OFS_IRQ_ENABLE: begin
        readWord[15:0] = enable;
      end
      default: begin
        readWord = 32'h0000_0000;
      end
    endcase
  endfunction

  // ==========================================================
  // declarations
  // ==========================================================
  logic setupStb;
  logic accessStb;
  logic wrStb;
  logic rdStb;
  logic wrFlags1;
  logic wrFlags2;
  logic wrIrqClear;
  logic wrIrqEnable;

  logic [7:0] wdata8;
  logic [15:0] wdata16;

  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] keep1;
  logic [7:0] keep2;
  logic [7:0] flags1_d;
  logic [7:0] flags1_q;
  logic [7:0] flags2_d;
  logic [7:0] flags2_q;
  logic [7:0] uartBits;
  logic [7:0] flags1View;
  logic [7:0] flags2View;

  logic [15:0] evtVec;
  logic [15:0] irqClear;
  logic [15:0] irqStatus_d;
  logic [15:0] irqStatus_q;
  logic [15:0] irqEnable_d;
  logic [15:0] irqEnable_q;
  logic [15:0] irqPending;

  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic slverr_d;
  logic slverr_q;

  // ==========================================================
  // bus phases and write strobes
  // ==========================================================
  assign setupStb = apbReq.psel & ~apbReq.penable;
  assign accessStb = apbReq.psel & apbReq.penable;
  // writes land at the end of the access cycle
  assign wrStb = accessStb & apbReq.pwrite;
  // reads are captured at the end of the setup cycle
  assign rdStb = setupStb & ~apbReq.pwrite;
  assign wrFlags1 = wrStb & hit(apbReq.paddr, OFS_FLAGS1);
  assign wrFlags2 = wrStb & hit(apbReq.paddr, OFS_FLAGS2);
  assign wrIrqClear = wrStb & hit(apbReq.paddr, OFS_IRQ_CLEAR);
  assign wrIrqEnable = wrStb & hit(apbReq.paddr, OFS_IRQ_ENABLE);
  assign wdata8 = apbReq.pwdata[7:0];
  assign wdata16 = apbReq.pwdata[15:0];

  // ==========================================================
  // hardware set vectors
  // ==========================================================
  always_comb begin
    set1 = 8'h00;
    set1[F1_SYNC_SERIAL] = events.syncSerialDone; // RULE_01
    set1[F1_BUS_COLLISION] = events.busCollision; // RULE_02
    set1[F1_TIMER_A_OVF] = events.timerAOverflow; // RULE_04
    set1[F1_TIMER_B_MATCH] = events.timerBMatch; // RULE_14
    set2 = 8'h00;
    set2[F2_TIMER_F_MATCH] = events.timerFMatch; // RULE_11
    set2[F2_COMPARATOR_TWO] = events.comparatorTwo; // RULE_15
    set2[F2_COMPARATOR_ONE] = events.comparatorOne; // RULE_15
    set2[F2_MEMORY_DONE] = events.memoryDone; // RULE_12
    set2[F2_TIMER_D_MATCH] = events.timerDMatch; // RULE_15
    set2[F2_OSC_ROLLOVER] = events.oscRollover; // RULE_13
  end

  always_comb begin
    uartBits = 8'h00;
    uartBits[F1_UART_RX_PEND] = uartLevels.rxNotEmpty; // RULE_10
    uartBits[F1_UART_TX_EMPTY] = uartLevels.txEmpty; // RULE_10
  end

  // ==========================================================
  // request flags
  // ==========================================================
  // no enable term reaches the set path; a set in a clearing cycle wins
  always_comb begin
    keep1 = flags1_q;
    if (wrFlags1) begin
      keep1 = clearByZero(flags1_q, wdata8, F1_RW_MASK); // RULE_03
    end
    flags1_d = (keep1 | set1) & F1_RW_MASK; // RULE_05 RULE_06
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      flags1_q <= FLAGS_RESET;
    end else begin
      flags1_q <= flags1_d; // RULE_03
    end
  end

  // unimplemented bits are masked on every update
  always_comb begin
    keep2 = flags2_q;
    if (wrFlags2) begin
      keep2 = clearByZero(flags2_q, wdata8, F2_RW_MASK); // RULE_03
    end
    flags2_d = (keep2 | set2) & F2_RW_MASK; // RULE_05 RULE_06 RULE_08
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      flags2_q <= FLAGS_RESET; // RULE_09
    end else begin
      flags2_q <= flags2_d;
    end
  end

  // ==========================================================
  // interrupt status, clear, enable
  // ==========================================================
  // status is its own sticky copy of the events, apart from the flags
  assign evtVec = {set2, set1};

  always_comb begin
    irqClear = IRQ_RESET;
    if (wrIrqClear) begin
      irqClear = wdata16;
    end
  end

  always_comb begin
    irqStatus_d = (irqStatus_q & ~irqClear) | evtVec;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      irqStatus_q <= IRQ_RESET;
    end else begin
      irqStatus_q <= irqStatus_d;
    end
  end

  always_comb begin
    irqEnable_d = irqEnable_q;
    if (wrIrqEnable) begin
      irqEnable_d = wdata16;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      irqEnable_q <= IRQ_RESET;
    end else begin
      irqEnable_q <= irqEnable_d;
    end
  end

  assign irqPending = irqStatus_q & irqEnable_q;
  assign irqOut = |irqPending;

  // ==========================================================
  // read data, captured in setup, answered in the access cycle
  // ==========================================================
  // uart levels are mirrored live, never stored
  assign flags1View = flags1_q | uartBits; // RULE_10
  assign flags2View = flags2_q & F2_RW_MASK; // RULE_08

  always_comb begin
    rdata_d = readWord(apbReq.paddr, flags1View, flags2View, irqStatus_q, irqEnable_q);
  end

  always_comb begin
    slverr_d = ~mapped(apbReq.paddr);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (rdStb) begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      slverr_q <= 1'b0;
    end else if (setupStb) begin
      slverr_q <= slverr_d;
    end
  end

  // every access completes in one access cycle
  assign apbRsp.prdata = rdata_q;
  assign apbRsp.pready = 1'b1;
  assign apbRsp.pslverr = slverr_q & accessStb;

endmodule

//--- tb/flag_bank_properties.sv
// Purpose: port-level checks of the request flag bank
// Assumes: flags are read right after their event
// Notes: bound to the top module
`timescale 1ns/1ps
module flag_bank_checker
  import irq_flag_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input irq_flag_pkg::apb_req_t apbReq,
  input irq_flag_pkg::apb_rsp_t apbRsp,
  input irq_flag_pkg::periph_events_t events,
  input irq_flag_pkg::uart_levels_t uartLevels,
  input wire logic irqOut
);
  // =====
  // properties
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence rdSetup(logic [11:0] a);
    apbReq.psel && !apbReq.penable && !apbReq.pwrite && apbReq.paddr == a;
  endsequence
  property setRead(logic e, logic [11:0] a, int b);
    e ##1 rdSetup(a) |=> apbRsp.prdata[b];
  endproperty
  a_serial_done_set: assert property (setRead(events.syncSerialDone, OFS_FLAGS1, 3))
    else $error("serial flag unset");
  a_collision_set: assert property (setRead(events.busCollision, OFS_FLAGS1, 2))
    else $error("collision flag unset");
  a_timer_a_set: assert property (setRead(events.timerAOverflow, OFS_FLAGS1, 0))
    else $error("timer a flag unset");
  a_timer_b_set: assert property (setRead(events.timerBMatch, OFS_FLAGS1, 1))
    else $error("timer b flag unset");
  a_timer_f_set: assert property (setRead(events.timerFMatch, OFS_FLAGS2, 7))
    else $error("timer f flag unset");
  a_memory_set: assert property (setRead(events.memoryDone, OFS_FLAGS2, 4))
    else $error("memory flag unset");
  a_osc_set: assert property (setRead(events.oscRollover, OFS_FLAGS2, 0))
    else $error("osc flag unset");
  a_comp_two_set: assert property (setRead(events.comparatorTwo, OFS_FLAGS2, 6))
    else $error("comparator flag unset");
  a_unused_zero: assert property (rdSetup(OFS_FLAGS2) |=> apbRsp.prdata[3:2] == 2'b00)
    else $error("unused bits set");
  a_uart_mirror: assert property (rdSetup(OFS_FLAGS1) |=>
    apbRsp.prdata[5:4] == $past({uartLevels.rxNotEmpty, uartLevels.txEmpty}))
    else $error("uart bits wrong");
endmodule
bind peripheral_irq_flag_bank flag_bank_checker chkI(.clock(clock), .nrst(nrst),
  .apbReq(apbReq), .apbRsp(apbRsp), .events(events), .uartLevels(uartLevels), .irqOut(irqOut));

//--- tb/event_source.sv
// Purpose: peripheral event sources feeding the flag bank
// Assumes: called just after a rising edge
// Notes: every event is a one-cycle pulse
`timescale 1ns/1ps
module event_source
  import irq_flag_pkg::*;
(
  input wire logic clock,
  output irq_flag_pkg::periph_events_t events
);
  initial events = '0;
  task automatic pulse(input periph_events_t e);
    events <= e;
    @(posedge clock);
    events <= '0;
  endtask
endmodule

//--- tb/tb.sv
// Purpose: register-level tests of the request flag bank
// Assumes: pready answers with no fixed latency
// Notes: interrupt enable stays zero through the event and clear tests, and is set to 1 for the irq test
`timescale 1ns/1ps
module tb;
  import irq_flag_pkg::*;
  logic clock = 0;
  logic nrst = 0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  periph_events_t events;
  uart_levels_t uartLevels = '0;
  logic irqOut;
  logic err;
  logic [31:0] rdata;
  logic [31:0] e1 = '0;
  logic [31:0] e2 = '0;
  int miscompares = 0;
  int n_checks = 0;
  always #25 clock = ~clock;
  peripheral_irq_flag_bank dut(.clock(clock), .nrst(nrst), .apbReq(req), .apbRsp(rsp),
    .events(events), .uartLevels(uartLevels), .irqOut(irqOut));
  event_source src(.clock(clock), .events(events));
  // =====
  // tasks
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(logic [11:0] a, logic w, logic [31:0] d);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge clock);
    req.penable <= 1'b1;
    do @(posedge clock); while (rsp.pready !== 1'b1);
    rdata = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] exp);
    xfer(a, 1'b0, '0);
    chk($sformatf("reg %h", a), exp, rdata);
  endtask
  task automatic irq(logic exp);
    #1 chk("irqOut", {31'h0, exp}, {31'h0, irqOut});
    @(posedge clock);
  endtask
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clock);
    miscompares++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 5; i++) rd(12'(4 * i), 32'h0);
    $display("test reset done");
    for (int i = 9; i >= 0; i--) begin
      src.pulse(periph_events_t'(10'h1 << i));
      if (i >= 6) begin
        e1[i - 6] = 1'b1;
        rd(OFS_FLAGS1, e1);
      end else begin
        e2[i >= 2 ? i + 2 : i] = 1'b1;
        rd(OFS_FLAGS2, e2);
      end
    end
    irq(1'b0);
    rd(OFS_IRQ_STATUS, 32'hf30f);
    $display("test events done");
    xfer(OFS_FLAGS1, 1'b1, 32'h0e);
    rd(OFS_FLAGS1, 32'h0e);
    xfer(OFS_FLAGS2, 1'b1, 32'h0c);
    rd(OFS_FLAGS2, 32'h0);
    uartLevels <= '1;
    xfer(OFS_FLAGS1, 1'b1, 32'h0);
    rd(OFS_FLAGS1, 32'h30);
    $display("test clear done");
    xfer(OFS_IRQ_CLEAR, 1'b1, 32'hffff);
    rd(OFS_IRQ_STATUS, 32'h0);
    xfer(OFS_IRQ_ENABLE, 1'b1, 32'h1);
    rd(OFS_IRQ_ENABLE, 32'h1);
    src.pulse(periph_events_t'(10'h010));
    irq(1'b0);
    src.pulse(periph_events_t'(10'h040));
    irq(1'b1);
    rd(OFS_IRQ_STATUS, 32'h4001);
    xfer(OFS_IRQ_CLEAR, 1'b1, 32'h1);
    irq(1'b0);
    rd(12'h020, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    $display("test irq done");
    end_of_test();
  end
endmodule
